// ===== src/asp_defs.vh
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH

// command byte and register widths
`define ASP_CMD_W 8
`define ASP_DATA_W 16

// command byte fields
`define ASP_CMD_RDY_BIT 7
`define ASP_CMD_SEL_HI 5
`define ASP_CMD_SEL_LO 4
`define ASP_CMD_RD_BIT 3

// register select codes
`define ASP_SEL_CMD 2'h0
`define ASP_SEL_SETUP 2'h1
`define ASP_SEL_DATA 2'h2
`define ASP_SEL_NONE 2'h3

// reset values
`define ASP_CMD_RST 8'h00
`define ASP_SETUP_RST 8'h00
`define ASP_DATA_RST 16'h0000

// run of ones that resets the port, in serial clocks
`define ASP_ONES_RUN 6'h20

// byte and word lengths in serial clocks
`define ASP_LEN_BYTE 5'h08
`define ASP_LEN_WORD 5'h10

`endif

// ===== src/asp_port.v
`timescale 1ns/1ps
`default_nettype none
`include "asp_defs.vh"

module asp_port #(
   parameter DW = `ASP_DATA_W
)(
   // clock and reset
   input wire clk,
   input wire rst_n,
   // serial pins
   input wire cs_n,
   input wire sclk,
   input wire din,
   output reg dout,
   output reg dout_oe,
   output reg sample_ready_n,
   // conversion word stream
   input wire word_valid,
   input wire [DW-1:0] word_data,
   output reg word_ready,
   // register contents to the converter
   output reg [`ASP_CMD_W-1:0] cmd_q,
   output reg [`ASP_CMD_W-1:0] setup_q
);

   // phase states
   localparam [2:0] ST_CMD = 3'b001;
   localparam [2:0] ST_WR = 3'b010;
   localparam [2:0] ST_RD = 3'b100;

   // access length in serial clocks for a register select
   function [4:0] acc_len;
      input [1:0] s;
      begin
         acc_len = (s == `ASP_SEL_DATA) ? `ASP_LEN_WORD : `ASP_LEN_BYTE;
      end
   endfunction

   // pin synchronisers, third stage only for edge detection
   reg sclk_s1, sclk_s2, sclk_s3;
   reg cs_s1, cs_s2;
   reg din_s1, din_s2;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end
      else
      begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         din_s1 <= din;
         din_s2 <= din_s1;
      end
   end

   wire sclk_rise = sclk_s2 & ~sclk_s3;
   wire sclk_fall = ~sclk_s2 & sclk_s3;

   // two-entry buffer for conversion words
   reg [DW-1:0] buf_mem [0:1];
   reg buf_wp_r, buf_rp_r;
   reg [1:0] buf_cnt_r;
   reg [1:0] buf_cnt_nxt;
   wire buf_push = word_valid & word_ready;
   wire buf_pop;
   always @*
   begin
      buf_cnt_nxt = buf_cnt_r;
      if (buf_push && !buf_pop)
         buf_cnt_nxt = buf_cnt_r + 2'h1;
      else if (buf_pop && !buf_push)
         buf_cnt_nxt = buf_cnt_r - 2'h1;
   end

   // buffer pointers; ready drops when both entries are taken
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_wp_r <= 1'b0;
         buf_rp_r <= 1'b0;
         buf_cnt_r <= 2'h0;
         word_ready <= 1'b0;
      end
      else
      begin
         if (buf_push)
            buf_wp_r <= ~buf_wp_r;
         if (buf_pop)
            buf_rp_r <= ~buf_rp_r;
         buf_cnt_r <= buf_cnt_nxt;
         word_ready <= (buf_cnt_nxt != 2'h2);
      end
   end

   // buffer storage, no reset needed
   always @(posedge clk)
   begin
      if (buf_push)
         buf_mem[buf_wp_r] <= word_data;
   end

   // serial engine state
   reg [2:0] state_r;
   reg [1:0] sel_r;
   reg [4:0] bit_cnt_r;
   reg [5:0] ones_r;
   reg [DW-1:0] in_sh_r;
   reg [DW-1:0] out_sh_r;
   reg [DW-1:0] data_r;
   reg upd_r;

   // bits in on din, out on dout
   wire [DW-1:0] in_word = {in_sh_r[DW-2:0], din_s2};
   wire [4:0] len_now = acc_len(sel_r);
   wire ones_hit = din_s2 && (ones_r == `ASP_ONES_RUN - 6'h01);

   // a result read in progress holds off the next update
   wire data_rd_busy = (state_r == ST_RD) && (sel_r == `ASP_SEL_DATA) && !cs_s2;
   assign buf_pop = upd_r;

   // readback word, left aligned so the msb leaves first
   reg [DW-1:0] rd_word;
   reg [`ASP_CMD_W-1:0] new_cmd;
   always @*
   begin
      new_cmd = in_word[`ASP_CMD_W-1:0];
      rd_word = {DW{1'b0}};
      case (new_cmd[`ASP_CMD_SEL_HI:`ASP_CMD_SEL_LO])
         `ASP_SEL_CMD: rd_word[DW-1:DW-8] = {sample_ready_n, new_cmd[6:0]};
         `ASP_SEL_SETUP: rd_word[DW-1:DW-8] = setup_q;
         `ASP_SEL_DATA: rd_word = data_r;
         default: rd_word = {DW{1'b0}};
      endcase
   end

   // main serial engine, ready flag and result update
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_CMD;
         sel_r <= `ASP_SEL_CMD;
         bit_cnt_r <= 5'h00;
         ones_r <= 6'h00;
         in_sh_r <= {DW{1'b0}};
         out_sh_r <= {DW{1'b0}};
         data_r <= `ASP_DATA_RST;
         upd_r <= 1'b0;
         sample_ready_n <= 1'b1;
         cmd_q <= `ASP_CMD_RST;
         setup_q <= `ASP_SETUP_RST;
      end
      else
      begin
         // raise sample_ready_n one cycle ahead of the load, drop it with the load
         if (upd_r)
         begin
            data_r <= buf_mem[buf_rp_r];
            upd_r <= 1'b0;
            sample_ready_n <= 1'b0;
         end
         else if (buf_cnt_r != 2'h0 && !data_rd_busy)
         begin
            upd_r <= 1'b1;
            sample_ready_n <= 1'b1;
         end
         if (cs_s2)
         begin
            bit_cnt_r <= 5'h00;
            ones_r <= 6'h00;
         end
         else if (sclk_rise)
         begin
            ones_r <= din_s2 ? ones_r + 6'h01 : 6'h00;
            // run of ones resets the port
            if (ones_hit)
            begin
               state_r <= ST_CMD;
               bit_cnt_r <= 5'h00;
               ones_r <= 6'h00;
            end
            else
            begin
               // din taken on the rising edge
               case (state_r)
                  ST_CMD:
                  begin
                     in_sh_r <= in_word;
                     bit_cnt_r <= bit_cnt_r + 5'h01;
                     if (bit_cnt_r == `ASP_LEN_BYTE - 5'h01)
                     begin
                        cmd_q <= new_cmd;
                        sel_r <= new_cmd[`ASP_CMD_SEL_HI:`ASP_CMD_SEL_LO];
                        bit_cnt_r <= 5'h00;
                        if (new_cmd[`ASP_CMD_RD_BIT])
                        begin
                           state_r <= ST_RD;
                           out_sh_r <= rd_word;
                        end
                        else
                           state_r <= ST_WR;
                     end
                  end
                  ST_WR:
                  begin
                     in_sh_r <= in_word;
                     bit_cnt_r <= bit_cnt_r + 5'h01;
                     if (bit_cnt_r == len_now - 5'h01)
                     begin
                        state_r <= ST_CMD;
                        bit_cnt_r <= 5'h00;
                        // only setup is writable besides command
                        if (sel_r == `ASP_SEL_SETUP)
                           setup_q <= in_word[`ASP_CMD_W-1:0];
                        else if (sel_r == `ASP_SEL_CMD)
                           cmd_q <= in_word[`ASP_CMD_W-1:0];
                     end
                  end
                  ST_RD:
                  begin
                     bit_cnt_r <= bit_cnt_r + 5'h01;
                     if (bit_cnt_r == len_now - 5'h01)
                     begin
                        state_r <= ST_CMD;
                        bit_cnt_r <= 5'h00;
                        if (sel_r == `ASP_SEL_DATA && !upd_r)
                           sample_ready_n <= 1'b1;
                     end
                  end
                  default:
                  begin
                     state_r <= ST_CMD;
                     bit_cnt_r <= 5'h00;
                  end
               endcase
            end
         end
         // dout moves on the falling edge after a bit was taken
         else if (sclk_fall && state_r == ST_RD && bit_cnt_r != 5'h00)
            out_sh_r <= {out_sh_r[DW-2:0], 1'b0};
      end
   end

   // output pin drive
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
      end
      else
      begin
         // msb stands as soon as cs_n falls in a read
         dout_oe <= !cs_s2 && (state_r == ST_RD);
         dout <= (!cs_s2 && state_r == ST_RD) ? out_sh_r[DW-1] : 1'b0;
      end
   end

endmodule // asp_port
`default_nettype wire

// ===== tb/asp_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module asp_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins
   input wire logic cs_n,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic sample_ready_n,
   // stream and registers
   input wire logic word_valid,
   input wire logic word_ready,
   input wire logic [7:0] cmd_q,
   input wire logic [7:0] setup_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // reset check must run while reset is low
   // first edge of reset only starts the flops, so look one edge later
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n ##1 !rst_n |-> !dout_oe && sample_ready_n && setup_q == 8'h00)
      else $error("pins not quiet in reset");
   a_deselect_off: assert property (cs_n [*5] |-> !dout_oe)
      else $error("dout driven while deselected");
   a_release_low: assert property (!dout_oe |-> !dout)
      else $error("dout not low when released");
   // idle port: a fresh word must show up soon
   a_fresh_ready: assert property (word_valid && word_ready && cs_n && $past(cs_n, 4) |-> ##[1:12] !sample_ready_n)
      else $error("fresh word not flagged");
   a_full_refuse: assert property ($fell(word_ready) |-> $past(word_valid))
      else $error("buffer closed without a word");
   a_ready_start: assert property ($rose(rst_n) |=> word_ready)
      else $error("buffer not open after reset");
   a_setup_sel: assert property ($changed(setup_q) |-> !$past(cs_n))
      else $error("setup changed while deselected");
   a_cmd_sel: assert property ($changed(cmd_q) |-> !$past(cs_n))
      else $error("command changed while deselected");
endmodule // asp_chk
bind asp_port asp_chk u_chk (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
   .sample_ready_n(sample_ready_n), .word_valid(word_valid), .word_ready(word_ready), .cmd_q(cmd_q),
   .setup_q(setup_q));
`default_nettype wire

// ===== tb/asp_host.sv
`timescale 1ns/1ps
`default_nettype none
module asp_host (
   // clock
   input wire logic clk,
   // serial pins
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b1;
   end
   // inputs move just after an edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic spin(input int n);
      repeat (n)
      begin
         sclk = 1'b0;
         wt(4);
         sclk = 1'b1;
         wt(4);
      end
   endtask
   // msb first, 400 ns sclk, read mid high half
   task automatic xfer(input int n, input logic [63:0] w, output logic [63:0] r);
      r = '0;
      cs_n = 1'b0;
      wt(4);
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk = 1'b0;
         din = w[i];
         wt(4);
         sclk = 1'b1;
         wt(2);
         r = {r[62:0], dout};
         wt(2);
      end
      cs_n = 1'b1;
      din = ~din; // no stale level left on din
      wt(6);
   endtask
endmodule // asp_host
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic word_valid = 1'b0;
   logic [15:0] word_data = 16'h0000;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic sample_ready_n;
   logic word_ready;
   logic [7:0] cmd_q;
   logic [7:0] setup_q;
   // released dout floats to the pull-up level
   wire host_rx = dout_oe ? dout : 1'b1;
   int err_total = 0;
   int total_checks = 0;
   int stalls = 0;
   logic [31:0] seed = 32'h0000_004a;
   logic [31:0] v;
   logic [63:0] r;
   logic [15:0] res_m;
   logic [7:0] set_m;
   logic [15:0] q[$];
   // 20 MHz system clock
   always #25 clk = ~clk;
   asp_port #(.DW(16)) dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe(dout_oe), .sample_ready_n(sample_ready_n), .word_valid(word_valid), .word_data(word_data),
      .word_ready(word_ready), .cmd_q(cmd_q), .setup_q(setup_q));
   asp_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(host_rx));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // model: words land in order, the newest one stays
   task automatic drain();
      while (q.size() > 0)
         res_m = q.pop_front();
   endtask
   // valid stays up between back-to-back words
   task automatic push(input logic [15:0] d);
      word_data = d;
      word_valid = 1'b1;
      while (word_ready !== 1'b1 && stalls < 999)
      begin
         stalls++;
         host.wt(1);
      end
      // a buffer that never opens counts as a failure
      if (stalls >= 999)
         err_total++;
      host.wt(1);
      q.push_back(d);
   endtask
   initial
   begin
      host.wt(5);
      chk({dout_oe, sample_ready_n, cmd_q, setup_q}, 18'h1_0000);
      host.wt(1);
      rst_n = 1'b1;
      host.wt(4);
      // command byte first, then the access
      v = xs();
      set_m = v[7:0];
      host.xfer(16, {48'h0, 8'h10, set_m}, r);
      chk(setup_q, set_m);
      host.xfer(16, {48'h0, 8'h18, 8'h00}, r);
      chk(r[7:0], set_m);
      $display("test setup done");
      for (int k = 0; k < 2; k++)
      begin
         host.xfer(16, {48'h0, 8'h08, 8'h00}, r);
         chk(r[7:0], {~k[0], 7'h08});
         v = xs();
         push(v[15:0]);
         word_valid = 1'b0;
         host.wt(12);
         drain();
         chk(sample_ready_n, 1'b0);
      end
      host.xfer(24, {40'h0, 8'h28, 16'h0000}, r);
      chk(r[15:0], res_m);
      chk(sample_ready_n, 1'b1);
      host.xfer(8, {56'h0, 8'h28}, r);
      chk(cmd_q, 8'h28);
      host.spin(3);
      host.xfer(16, 64'h0, r);
      chk(r[15:0], res_m);
      $display("test result read done");
      // words during a read wait in the buffer
      stalls = 0;
      fork
         host.xfer(24, {40'h0, 8'h28, 16'h0000}, r);
         begin
            host.wt(90);
            repeat (3)
            begin
               v = xs();
               push(v[15:0]);
            end
            word_valid = 1'b0;
         end
      join
      chk(r[15:0], res_m);
      chk(stalls > 0, 1'b1);
      host.wt(12);
      drain();
      host.xfer(24, {40'h0, 8'h28, 16'h0000}, r);
      chk(r[15:0], res_m);
      $display("test stall done");
      // mid-run reset clears port and result
      rst_n = 1'b0;
      host.wt(2);
      chk({dout_oe, sample_ready_n, cmd_q, setup_q}, 18'h1_0000);
      rst_n = 1'b1;
      host.wt(4);
      res_m = 16'h0000;
      // recovery: 24-clock read, then 32 ones
      host.xfer(24, {40'h0, 8'h28, 16'h0000}, r);
      chk(r[15:0], res_m);
      host.xfer(32, 64'hffff_ffff, r);
      v = xs();
      set_m = v[7:0];
      host.xfer(16, {48'h0, 8'h10, set_m}, r);
      chk(setup_q, set_m);
      $display("test reset done");
      // 32 ones after a read command end a pending command byte
      host.xfer(40, {24'h0, 8'h38, 32'hffff_ffff}, r);
      chk(setup_q, set_m);
      v = xs();
      host.xfer(16, {48'h0, 8'h10, v[7:0]}, r);
      chk(setup_q, v[7:0]);
      $display("test ones reset done");
      finish_test();
   end
   // about 2500 cycles expected
   initial
   begin
      #1_000_000;
      err_total++;
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
